//--- logic/pmcd_defs.svh
// register map, field positions, reset values and phase lengths
`ifndef PMCD_DEFS_SVH
`define PMCD_DEFS_SVH

// register indices; the byte address is four times the index
`define PMCD_PMR_IDX        10'h0D0
`define PMCD_STATUS_IDX     10'h0C5
`define PMCD_TCS_IDX        10'h08E

// power mode control fields
`define PMCD_DIV_HI_BIT     7
`define PMCD_DIV_LO_BIT     6
`define PMCD_SWB_BIT        5
`define PMCD_PMR_RESET      8'h40

// activity status fields
`define PMCD_PFAIL_BIT      7
`define PMCD_HIP_BIT        6
`define PMCD_LIP_BIT        5
`define PMCD_UB_TX_BIT      3
`define PMCD_UB_RX_BIT      2
`define PMCD_UA_TX_BIT      1
`define PMCD_UA_RX_BIT      0
`define PMCD_STATUS_RESET   8'h00

// timer clock select: one bit per timer, timer 0 lowest
`define PMCD_TCS_LSB        3
`define PMCD_TCS_RESET      3'h0

// oscillator clocks per internal phase
`define PMCD_PHASE_LEN_4    9'h001
`define PMCD_PHASE_LEN_64   9'h010
`define PMCD_PHASE_LEN_1024 9'h100

// internal clocks per legacy timer count
`define PMCD_LEGACY_DIV     12

`endif

//--- logic/pmcd_pkg.sv
// types shared by the clock divider modules
package pmcd_pkg;

   // divider code as held in the power mode control field
   typedef enum logic [1:0] {
      PMCD_DIV_RSV  = 2'h0,
      PMCD_DIV_4    = 2'h1,
      PMCD_DIV_64   = 2'h2,
      PMCD_DIV_1024 = 2'h3
   } pmcd_div_t;

   // the four internal clock phases of a machine cycle
   typedef enum logic [3:0] {
      PMCD_C1 = 4'h1,
      PMCD_C2 = 4'h2,
      PMCD_C3 = 4'h4,
      PMCD_C4 = 4'h8
   } pmcd_phase_t;

endpackage

//--- logic/pmcd_phase_gen.sv
// phase sequencer: stretches each internal phase by the active divider
`timescale 1ns/1ps
`include "pmcd_defs.svh"
module pmcd_phase_gen (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              arst_n,
   // requested divider
   input  wire pmcd_pkg::pmcd_div_t div_req,
   // phase outputs
   output pmcd_pkg::pmcd_phase_t  phase,
   output logic                   phase_en,
   output logic                   mcycle_end,
   output pmcd_pkg::pmcd_div_t    div_active
);
   import pmcd_pkg::*;

   logic [7:0]  cnt;
   logic [7:0]  next_cnt;
   pmcd_phase_t next_phase;
   pmcd_div_t   next_div;

   // last prescale count of a phase for a divider code
   function automatic logic [7:0] phase_last(input pmcd_div_t d);
      logic [8:0] len;
      len = `PMCD_PHASE_LEN_4;
      if (d == PMCD_DIV_64) begin
         len = `PMCD_PHASE_LEN_64;
      end else if (d == PMCD_DIV_1024) begin
         len = `PMCD_PHASE_LEN_1024;
      end
      return 8'(len - 9'h001);
   endfunction

   // one enable per internal clock; the oscillator itself never stops
   assign phase_en   = (cnt == phase_last(div_active));
   assign mcycle_end = phase_en && (phase == PMCD_C4);

   // next prescale, phase and divider
   always_comb begin
      next_cnt   = cnt + 8'h01;
      next_phase = phase;
      next_div   = div_active;
      if (phase_en) begin
         next_cnt = 8'h00;
         unique case (phase)
            PMCD_C1: next_phase = PMCD_C2;
            PMCD_C2: next_phase = PMCD_C3;
            PMCD_C3: next_phase = PMCD_C4;
            PMCD_C4: next_phase = PMCD_C1;
            default: next_phase = PMCD_C1;
         endcase
      end
      // R21: boundary-only change
      if (mcycle_end && div_req != PMCD_DIV_RSV) begin
         next_div = div_req;
      end
   end

   // register the sequencer
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt        <= 8'h00;
         phase      <= PMCD_C1;
         div_active <= PMCD_DIV_4;
      end else begin
         cnt        <= next_cnt;
         phase      <= next_phase;
         div_active <= next_div;
      end
   end

endmodule

//--- logic/pmcd_timer_tick.sv
// per-timer count enables: legacy rate or one per machine cycle
`timescale 1ns/1ps
`include "pmcd_defs.svh"
module pmcd_timer_tick #(
   parameter int TIMERS   = 3,
   parameter int DIV_LONG = `PMCD_LEGACY_DIV
) (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              arst_n,
   // internal clock strobes
   input  wire logic              phase_en,
   input  wire logic              mcycle_end,
   // per-timer rate select, 1 = machine cycle
   input  wire logic [TIMERS-1:0] sel,
   // count enables
   output logic      [TIMERS-1:0] tick
);

   // the legacy prescaler is four bits wide, so at most 16 phases per count
   if (TIMERS < 1 || DIV_LONG < 1 || DIV_LONG > 16) begin : g_bad_param
      $error("pmcd_timer_tick: unsupported TIMERS or DIV_LONG");
   end

   localparam logic [3:0] LAST = 4'(DIV_LONG - 1);

   for (genvar t = 0; t < TIMERS; t++) begin : g_tmr
      logic [3:0] cnt;
      logic [3:0] next_cnt;
      logic       wrap;

      assign wrap = phase_en && (cnt == LAST);

      // legacy prescale over internal clocks
      always_comb begin
         next_cnt = cnt;
         if (phase_en) begin
            next_cnt = wrap ? 4'h0 : cnt + 4'h1;
         end
      end

      always_ff @(posedge clk or negedge arst_n) begin
         if (!arst_n) begin
            cnt <= 4'h0;
         end else begin
            cnt <= next_cnt;
         end
      end

      // R16: per-timer rate choice
      assign tick[t] = sel[t] ? mcycle_end : wrap;
   end

endmodule

//--- logic/pmcd_top.sv
// power management clock divider with register slave and switchback
//
// How it works
// R01: divider code 01/10/11 gives 4/64/1024 clocks per cycle, 00 reserved, resets 01.
// R02: code 01 always writable; 10 and 11 only from 01.
// R03: an illegal divider write leaves the field unchanged.
// R04: switchback enable resets 0; when 0 events never touch the divider.
// R05: switchback returns either slow mode to divide-by-4.
// R06: status bit 7 shows power-fail interrupt in service, resets 0.
// R07: status bit 6 shows high-priority interrupt in progress, resets 0.
// R08: status bit 5 shows low-priority interrupt in progress, resets 0.
// R09: status bits 3/2 show second uart transmit/receive activity.
// R10: status bits 1/0 show first uart transmit/receive activity.
// R11: each phase lasts 16 or 256 clocks in slow modes, 1 normally.
// R12: only the internal clock is divided; the oscillator keeps running.
// R13: slow modes keep the four-phase timing, only stretched.
// R14: timers, baud and watchdog run from the divided internal clock.
// R15: timers default to one count per 12 internal clocks.
// R16: each timer select bit switches it to machine-cycle rate.
// R17: software checks serial activity before changing the divider.
// R18: software avoids slow modes or uses switchback for standard baud.
// R19: acknowledged interrupt or serial activity forces divide-by-4 when enabled.
// R20: receive fires on start-bit fall if enabled; transmit on buffer load.
// R21: divider changes take effect only at a machine-cycle boundary.
`timescale 1ns/1ps
`include "pmcd_defs.svh"
module pmcd_top (
   // clock and reset
   input  wire logic                 SYS_CLK,
   input  wire logic                 ARST_N,
   // avalon-mm slave
   input  wire logic [11:0]          AVS_ADDRESS,
   input  wire logic                 AVS_READ,
   input  wire logic                 AVS_WRITE,
   input  wire logic [31:0]          AVS_WRITEDATA,
   input  wire logic [3:0]           AVS_BYTEENABLE,
   output logic      [31:0]          AVS_READDATA,
   output logic                      AVS_WAITREQUEST,
   // interrupt logic, same clock
   input  wire logic                 IRQ_ACK,
   input  wire logic                 POWER_FAIL_IRQ_ACTIVE,
   input  wire logic                 HIGH_PRIO_IRQ_ACTIVE,
   input  wire logic                 LOW_PRIO_IRQ_ACTIVE,
   // serial ports, same clock
   input  wire logic                 UART_A_TX_ACTIVE,
   input  wire logic                 UART_A_RX_ACTIVE,
   input  wire logic                 UART_B_TX_ACTIVE,
   input  wire logic                 UART_B_RX_ACTIVE,
   input  wire logic                 UART_A_TX_LOAD,
   input  wire logic                 UART_B_TX_LOAD,
   input  wire logic                 UART_A_RX_ENABLE,
   input  wire logic                 UART_B_RX_ENABLE,
   // receive data pins, asynchronous
   input  wire logic                 UART_A_RXD_PIN,
   input  wire logic                 UART_B_RXD_PIN,
   // internal clock outputs
   output pmcd_pkg::pmcd_phase_t     PHASE,
   output logic                      PHASE_EN,
   output logic                      MCYCLE_END,
   output pmcd_pkg::pmcd_div_t       DIVIDER_MODE,
   output logic                      REDUCED_SPEED_MODE,
   output logic      [2:0]           TIMER_TICK
);
   import pmcd_pkg::*;

   localparam logic [11:0] ADDR_PMR    = {`PMCD_PMR_IDX, 2'h0};
   localparam logic [11:0] ADDR_STATUS = {`PMCD_STATUS_IDX, 2'h0};
   localparam logic [11:0] ADDR_TCS    = {`PMCD_TCS_IDX, 2'h0};

   // one-hot register select: bit 0 pmr, 1 status, 2 timer select
   function automatic logic [2:0] reg_sel(input logic [11:0] a);
      logic [2:0] s;
      s = 3'h0;
      if (a == ADDR_PMR) begin
         s = 3'h1;
      end else if (a == ADDR_STATUS) begin
         s = 3'h2;
      end else if (a == ADDR_TCS) begin
         s = 3'h4;
      end
      return s;
   endfunction

   // bus state
   logic        ack;
   logic        next_ack;
   logic [31:0] rdata;
   logic [31:0] next_rdata;
   logic [2:0]  sel;
   logic        wr_commit;

   // register state
   logic        divider_select_high;
   logic        divider_select_low;
   logic        switchback_enable;
   logic [2:0]  timer_clock_select_reg;
   logic [7:0]  activity_status;
   logic        next_div_hi;
   logic        next_div_lo;
   logic        next_swb;
   logic [2:0]  next_tcs;
   logic [7:0]  next_status;

   // receive pin synchronisers and edge stage
   logic [1:0]  rxd_s1;
   logic [1:0]  rxd_s2;
   logic [1:0]  rxd_s3;
   logic [1:0]  rx_fall;

   // divider control
   pmcd_div_t   div_cur;
   pmcd_div_t   div_wr;
   logic        div_legal;
   logic        switchback;
   pmcd_div_t   div_active;

   // ------------------------------------------------------------------
   // avalon handshake: one wait cycle, answer on the second
   // ------------------------------------------------------------------
   assign sel             = reg_sel(AVS_ADDRESS);
   assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !ack;
   assign wr_commit       = AVS_WRITE && ack && AVS_BYTEENABLE[0];
   assign AVS_READDATA    = rdata;

   // read data captured in the wait cycle so it stands when wait drops
   always_comb begin
      next_ack   = (AVS_READ || AVS_WRITE) && !ack;
      next_rdata = rdata;
      if (AVS_READ && !ack) begin
         next_rdata = 32'h0000_0000;
         unique case (1'b1)
            sel[0]: begin
               next_rdata[`PMCD_DIV_HI_BIT] = divider_select_high;
               next_rdata[`PMCD_DIV_LO_BIT] = divider_select_low;
               next_rdata[`PMCD_SWB_BIT]    = switchback_enable;
            end
            sel[1]: next_rdata[7:0] = activity_status;
            sel[2]: next_rdata[`PMCD_TCS_LSB +: 3] = timer_clock_select_reg;
            default: next_rdata = 32'h0000_0000; // unmapped reads zero
         endcase
      end
   end

   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         ack   <= 1'b0;
         rdata <= 32'h0000_0000;
      end else begin
         ack   <= next_ack;
         rdata <= next_rdata;
      end
   end

   // ------------------------------------------------------------------
   // receive pins: two flops, then a third for the falling edge
   // ------------------------------------------------------------------
   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         rxd_s1 <= 2'h3; // idle line is high
         rxd_s2 <= 2'h3;
         rxd_s3 <= 2'h3;
      end else begin
         rxd_s1 <= {UART_B_RXD_PIN, UART_A_RXD_PIN};
         rxd_s2 <= rxd_s1;
         rxd_s3 <= rxd_s2;
      end
   end

   // R20: start-bit edge detect
   assign rx_fall = rxd_s3 & ~rxd_s2;

   // ------------------------------------------------------------------
   // switchback sources
   // ------------------------------------------------------------------
   // R19: qualified events only when enabled
   // R04: enable gates every source
   assign switchback = switchback_enable
                       && (IRQ_ACK
                           || UART_A_TX_LOAD
                           || UART_B_TX_LOAD
                           || (rx_fall[0] && UART_A_RX_ENABLE)
                           || (rx_fall[1] && UART_B_RX_ENABLE));

   // ------------------------------------------------------------------
   // divider field and switchback enable
   // ------------------------------------------------------------------
   assign div_cur = pmcd_div_t'({divider_select_high, divider_select_low});
   assign div_wr  = pmcd_div_t'(AVS_WRITEDATA[`PMCD_DIV_HI_BIT:`PMCD_DIV_LO_BIT]);

   // R02: slow modes only from divide-by-4
   assign div_legal = (div_wr == PMCD_DIV_4)
                      || ((div_cur == PMCD_DIV_4) && (div_wr != PMCD_DIV_RSV));

   // switchback wins over a write landing in the same cycle
   always_comb begin
      next_div_hi = divider_select_high;
      next_div_lo = divider_select_low;
      next_swb    = switchback_enable;
      next_tcs    = timer_clock_select_reg;
      if (wr_commit && sel[0]) begin
         next_swb = AVS_WRITEDATA[`PMCD_SWB_BIT];
         // R03: illegal code leaves bits alone
         if (div_legal) begin
            next_div_hi = div_wr[1];
            next_div_lo = div_wr[0];
         end
      end
      if (wr_commit && sel[2]) begin
         next_tcs = AVS_WRITEDATA[`PMCD_TCS_LSB +: 3];
      end
      // R05: forced back to divide-by-4
      if (switchback) begin
         // whole-field assignment of the divide-by-4 code
         {next_div_hi, next_div_lo} = PMCD_DIV_4;
      end
   end

   // R01: field resets to divide-by-4
   // R15: timers reset to legacy rate
   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         divider_select_high    <= 1'(`PMCD_PMR_RESET >> `PMCD_DIV_HI_BIT);
         divider_select_low     <= 1'(`PMCD_PMR_RESET >> `PMCD_DIV_LO_BIT);
         switchback_enable      <= 1'(`PMCD_PMR_RESET >> `PMCD_SWB_BIT);
         timer_clock_select_reg <= `PMCD_TCS_RESET;
      end else begin
         divider_select_high    <= next_div_hi;
         divider_select_low     <= next_div_lo;
         switchback_enable      <= next_swb;
         timer_clock_select_reg <= next_tcs;
      end
   end

   // ------------------------------------------------------------------
   // activity status: a live copy of the core's flags, one cycle late
   // ------------------------------------------------------------------
   always_comb begin
      next_status = `PMCD_STATUS_RESET;
      // R06: power-fail in service
      next_status[`PMCD_PFAIL_BIT] = POWER_FAIL_IRQ_ACTIVE;
      // R07: high priority in progress
      next_status[`PMCD_HIP_BIT]   = HIGH_PRIO_IRQ_ACTIVE;
      // R08: low priority in progress
      next_status[`PMCD_LIP_BIT]   = LOW_PRIO_IRQ_ACTIVE;
      // R09: second uart activity
      next_status[`PMCD_UB_TX_BIT] = UART_B_TX_ACTIVE;
      next_status[`PMCD_UB_RX_BIT] = UART_B_RX_ACTIVE;
      // R10: first uart activity
      next_status[`PMCD_UA_TX_BIT] = UART_A_TX_ACTIVE;
      next_status[`PMCD_UA_RX_BIT] = UART_A_RX_ACTIVE;
   end

   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         activity_status <= `PMCD_STATUS_RESET;
      end else begin
         activity_status <= next_status;
      end
   end

   // ------------------------------------------------------------------
   // phase sequencer; the system clock is never gated, only enabled
   // ------------------------------------------------------------------
   // R11: phase length per mode
   // R12: oscillator untouched
   // R13: same phase order, stretched
   // R21: new divider applied at C4 end
   pmcd_phase_gen u_phase (
      .clk        (SYS_CLK),
      .arst_n     (ARST_N),
      .div_req    (div_cur),
      .phase      (PHASE),
      .phase_en   (PHASE_EN),
      .mcycle_end (MCYCLE_END),
      .div_active (div_active)
   );

   assign DIVIDER_MODE       = div_active;
   assign REDUCED_SPEED_MODE = (div_active != PMCD_DIV_4);

   // ------------------------------------------------------------------
   // timer count enables built on the divided clock
   // ------------------------------------------------------------------
   // R14: timers follow the divider
   // R15: legacy 12-clock default
   // R16: per-timer select
   pmcd_timer_tick #(
      .TIMERS   (3),
      .DIV_LONG (`PMCD_LEGACY_DIV)
   ) u_tick (
      .clk        (SYS_CLK),
      .arst_n     (ARST_N),
      .phase_en   (PHASE_EN),
      .mcycle_end (MCYCLE_END),
      .sel        (timer_clock_select_reg),
      .tick       (TIMER_TICK)
   );

endmodule

//--- sim/pmcd_top_asserts.sv
// port checker for the clock divider, bound to the top module
`timescale 1ns/1ps
`include "pmcd_defs.svh"
module pmcd_top_asserts
   import pmcd_pkg::*;
(
   // clock and reset
   input wire logic        SYS_CLK,
   input wire logic        ARST_N,
   // bus handshake
   input wire logic        AVS_READ,
   input wire logic        AVS_WRITE,
   input wire logic        AVS_WAITREQUEST,
   // internal clock outputs
   input wire pmcd_phase_t PHASE,
   input wire logic        PHASE_EN,
   input wire logic        MCYCLE_END,
   input wire pmcd_div_t   DIVIDER_MODE,
   input wire logic        REDUCED_SPEED_MODE,
   input wire logic [2:0]  TIMER_TICK
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!ARST_N);
   logic [8:0] gap;
   logic [8:0] next_gap;
   // clocks since the last phase strobe; too long for a repetition
   always_comb begin
      next_gap = PHASE_EN ? 9'h000 : gap + 9'h001;
   end
   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         gap <= 9'h000;
      end else begin
         gap <= next_gap;
      end
   end
   function automatic logic [8:0] plen(pmcd_div_t d);
      case (d)
         PMCD_DIV_64:   return `PMCD_PHASE_LEN_64;
         PMCD_DIV_1024: return `PMCD_PHASE_LEN_1024;
         default:       return `PMCD_PHASE_LEN_4;
      endcase
   endfunction
   property p_no_rsv; DIVIDER_MODE != PMCD_DIV_RSV; endproperty
   a_no_rsv: assert property (p_no_rsv) else $error("reserved divider active");
   property p_rsm; REDUCED_SPEED_MODE == (DIVIDER_MODE != PMCD_DIV_4); endproperty
   a_rsm: assert property (p_rsm) else $error("slow mode flag wrong");
   property p_plen; PHASE_EN |-> gap == plen(DIVIDER_MODE) - 9'h001; endproperty
   a_plen: assert property (p_plen) else $error("phase length wrong");
   property p_rot; PHASE_EN |=> PHASE == {$past(PHASE[2:0]), $past(PHASE[3])}; endproperty
   a_rot: assert property (p_rot) else $error("phase order wrong");
   property p_mce; MCYCLE_END == (PHASE_EN && PHASE == PMCD_C4); endproperty
   a_mce: assert property (p_mce) else $error("cycle end misplaced");
   property p_bound; !$stable(DIVIDER_MODE) |-> $past(MCYCLE_END); endproperty
   a_bound: assert property (p_bound) else $error("divider changed mid cycle");
   property p_tick; |TIMER_TICK |-> PHASE_EN; endproperty
   a_tick: assert property (p_tick) else $error("timer tick off strobe");
   property p_wait; (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST; endproperty
   a_wait: assert property (p_wait) else $error("bus answer late"); // one wait cycle
endmodule
bind pmcd_top pmcd_top_asserts u_chk (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N),
   .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WAITREQUEST(AVS_WAITREQUEST),
   .PHASE(PHASE), .PHASE_EN(PHASE_EN), .MCYCLE_END(MCYCLE_END),
   .DIVIDER_MODE(DIVIDER_MODE), .REDUCED_SPEED_MODE(REDUCED_SPEED_MODE),
   .TIMER_TICK(TIMER_TICK));

//--- sim/pmcd_core_model.sv
// core, interrupt and serial port model driving the divider's event inputs
`timescale 1ns/1ps
module pmcd_core_model (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       arst_n,
   // bench commands
   input  wire logic [6:0] act,
   input  wire logic [2:0] ev,
   input  wire logic [1:0] rx_low,
   input  wire logic [1:0] rx_en,
   // to the divider
   output logic      [6:0] act_o,
   output logic      [2:0] ev_o,
   output logic      [1:0] en_o,
   output logic      [1:0] rxd_o
);
   // qualified acks, buffer loads, start-bit falls
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         act_o <= 7'h00;
         ev_o  <= 3'h0;
         en_o  <= 2'h0;
         rxd_o <= 2'h3;
      end else begin
         act_o <= act;
         ev_o  <= ev;
         en_o  <= rx_en;
         rxd_o <= ~rx_low; // line idles high
      end
   end
endmodule

//--- sim/tb_power_management_clock_divider.sv
// register and timing tests for the clock divider
`timescale 1ns/1ps
`include "pmcd_defs.svh"
module tb_power_management_clock_divider;
   import pmcd_pkg::*;
   localparam logic [11:0] POWER_MODE_CONTROL = {`PMCD_PMR_IDX, 2'b00};
   localparam logic [11:0] STS = {`PMCD_STATUS_IDX, 2'b00};
   localparam logic [11:0] TCS = {`PMCD_TCS_IDX, 2'b00};
   logic clk = 1'b0, arst_n = 1'b0, rd = 1'b0, wr = 1'b0;
   logic [11:0] addr = 12'h000;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0]  be = 4'h0;
   logic [6:0]  act = 7'h00, act_o;
   logic [2:0]  ev = 3'h0, ev_o, tick;
   logic [1:0]  rx_low = 2'h0, rx_en = 2'h0, en_o, rxd_o;
   logic [31:0] rdata;
   logic        wait_r, pen, mce, rsm;
   pmcd_phase_t phase;
   pmcd_div_t   mode;
   int error_cnt = 0, checks_done = 0, n;
   logic [7:0] q;
   initial forever #12.5 clk = ~clk;
   pmcd_core_model u_model (.clk(clk), .arst_n(arst_n), .act(act), .ev(ev), .rx_low(rx_low),
      .rx_en(rx_en), .act_o(act_o), .ev_o(ev_o), .en_o(en_o), .rxd_o(rxd_o));
   pmcd_top uut (.SYS_CLK(clk), .ARST_N(arst_n), .AVS_ADDRESS(addr), .AVS_READ(rd),
      .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
      .AVS_WAITREQUEST(wait_r), .IRQ_ACK(ev_o[0]), .POWER_FAIL_IRQ_ACTIVE(act_o[6]),
      .HIGH_PRIO_IRQ_ACTIVE(act_o[5]), .LOW_PRIO_IRQ_ACTIVE(act_o[4]),
      .UART_B_TX_ACTIVE(act_o[3]), .UART_B_RX_ACTIVE(act_o[2]), .UART_A_TX_ACTIVE(act_o[1]),
      .UART_A_RX_ACTIVE(act_o[0]), .UART_A_TX_LOAD(ev_o[1]), .UART_B_TX_LOAD(ev_o[2]),
      .UART_A_RX_ENABLE(en_o[0]), .UART_B_RX_ENABLE(en_o[1]), .UART_A_RXD_PIN(rxd_o[0]),
      .UART_B_RXD_PIN(rxd_o[1]), .PHASE(phase), .PHASE_EN(pen), .MCYCLE_END(mce),
      .DIVIDER_MODE(mode), .REDUCED_SPEED_MODE(rsm), .TIMER_TICK(tick));
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t byte %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_cnt(input int got, input int exp);
      checks_done++;
      if (got != exp) begin
         error_cnt++;
         $display("[FAIL] %0t count %0d expected %0d", $time, got, exp);
      end
   endtask
   // one access; held until waitrequest is seen low at a rising edge
   task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d,
                      input logic [3:0] b);
      logic busy;
      busy = 1'b1;
      @(posedge clk);
      rd <= !w;
      wr <= w;
      addr <= a;
      wdata <= {24'h0, d};
      be <= b;
      // waitrequest and read data are seen as they stood before this edge
      while (busy) begin
         @(posedge clk);
         busy = (wait_r !== 1'b0);
      end
      q = rdata[7:0];
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic rchk(input logic [11:0] a, input logic [7:0] exp);
      bus(1'b0, a, 8'h00, 4'hf);
      chk_byte(q, exp);
   endtask
   task automatic step(input logic [7:0] d, input logic [7:0] exp);
      bus(1'b1, POWER_MODE_CONTROL, d, 4'hf);
      rchk(POWER_MODE_CONTROL, exp);
   endtask
   task automatic wait_mode(input pmcd_div_t m);
      int g;
      g = 0;
      do begin
         @(negedge clk);
         g++;
      end while (mode !== m && g < 2000);
      chk_byte({6'h00, mode}, {6'h00, m});
   endtask
   // clocks from one phase strobe to the next
   task automatic meas(output int len);
      @(negedge clk);
      while (pen !== 1'b1) @(negedge clk);
      len = 0;
      do begin
         @(negedge clk);
         len++;
      end while (pen !== 1'b1 && len < 600);
   endtask
   task automatic fire(input int k);
      @(posedge clk);
      if (k < 3) ev <= 3'h1 << k;
      else rx_low <= 2'h1 << (k - 3);
      repeat (4) @(posedge clk);
      ev <= 3'h0;
      rx_low <= 2'h0;
      repeat (6) @(posedge clk);
   endtask
   initial begin
      #(25 * 40000);
      error_cnt++;
      $display("[FAIL] %0t watchdog expired", $time);
      give_verdict();
   end
   initial begin
      repeat (8) @(posedge clk);
      arst_n <= 1'b1;
      rchk(POWER_MODE_CONTROL, 8'h40);
      rchk(STS, 8'h00);
      rchk(TCS, 8'h00);
      bus(1'b1, 12'h100, 8'hff, 4'hf);
      rchk(12'h100, 8'h00);
      bus(1'b1, POWER_MODE_CONTROL, 8'h80, 4'h0);
      rchk(POWER_MODE_CONTROL, 8'h40);
      $display("test reset and map done");
      step(8'h00, 8'h40);
      step(8'h80, 8'h80);
      step(8'hc0, 8'h80);
      wait_mode(PMCD_DIV_64);
      meas(n);
      chk_cnt(n, 16);
      step(8'h40, 8'h40);
      step(8'hc0, 8'hc0);
      step(8'h80, 8'hc0);
      wait_mode(PMCD_DIV_1024);
      meas(n);
      chk_cnt(n, 256);
      $display("test divider transitions done");
      fire(0);
      rchk(POWER_MODE_CONTROL, 8'hc0);
      step(8'he0, 8'he0);
      fire(0);
      rchk(POWER_MODE_CONTROL, 8'h60);
      wait_mode(PMCD_DIV_4);
      rx_en <= 2'h3;
      for (int k = 0; k < 6; k++) begin
         if (k == 5) rx_en <= 2'h0;
         rchk(STS, 8'h00);
         step(8'ha0, 8'ha0);
         fire(k == 5 ? 3 : k);
         rchk(POWER_MODE_CONTROL, k == 5 ? 8'ha0 : 8'h60);
      end
      step(8'h40, 8'h40);
      wait_mode(PMCD_DIV_4);
      $display("test switchback done");
      for (int i = 0; i < 7; i++) begin
         act <= 7'h01 << i;
         repeat (3) @(posedge clk);
         rchk(STS, {act[6:4], 1'b0, act[3:0]});
      end
      act <= 7'h00;
      $display("test status done");
      for (int i = 0; i < 3; i++) begin
         bus(1'b1, TCS, i == 0 ? 8'h00 : (i == 1 ? 8'h38 : 8'h08), 4'hf);
         for (int t = 0; t < 3; t++) begin
            n = 0;
            repeat (48) begin
               @(negedge clk);
               n += (tick[t] === 1'b1);
            end
            chk_cnt(n, (i == 1 || (i == 2 && t == 0)) ? 12 : 4);
         end
      end
      $display("test timers done");
      give_verdict();
   end
endmodule
